// File: rtl/move_exec_pkg.sv
// Shared constants, encodings and types for the data-move execution block.
package move_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int PTR_W   = 16;
  localparam int FILE_AW = 7;
  localparam int PAGE_W  = 7;
  localparam int STAT_W  = 3;
  localparam int OFF_W   = 6;

  // ----------------------------------------------------------------
  // Instruction encodings, as mask and pattern pairs
  // ----------------------------------------------------------------
  localparam logic [13:0] PAGE_MASK = 14'h3f80;
  localparam logic [13:0] PAGE_PAT  = 14'h3180;
  localparam logic [13:0] ACC_MASK  = 14'h3c00;
  localparam logic [13:0] ACC_PAT   = 14'h3000;
  localparam logic [13:0] FILE_MASK = 14'h3f80;
  localparam logic [13:0] FILE_PAT  = 14'h0080;
  localparam logic [13:0] IND_MASK  = 14'h3ff8;
  localparam logic [13:0] IND_PAT   = 14'h0018;
  localparam logic [13:0] REL_MASK  = 14'h3f80;
  localparam logic [13:0] REL_PAT   = 14'h3f80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CODE_LSB    = 0;
  localparam int IND_SEL_BIT = 2;
  localparam int REL_SEL_BIT = 6;
  localparam int OFF_LSB     = 0;
  localparam int LIT_LSB     = 0;
  localparam int FILE_LSB    = 0;

  // ----------------------------------------------------------------
  // Indirect window locations, reset values and pointer step
  // ----------------------------------------------------------------
  localparam logic [6:0]  WIN0_ADDR   = 7'h00;
  localparam logic [6:0]  WIN1_ADDR   = 7'h01;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [6:0]  PAGE_RST    = 7'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic [2:0]  STAT_RST    = 3'h0;
  localparam logic [15:0] PTR_STEP    = 16'h0001;

  // Pointer update codes in encoding order.
  typedef enum logic [1:0] {
    UPD_PRE_INC,
    UPD_PRE_DEC,
    UPD_POST_INC,
    UPD_POST_DEC
  } pointer_update_code_t;

  // Decoded instruction kind.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_PAGE,
    OP_ACC,
    OP_FILE,
    OP_IND,
    OP_REL
  } op_kind_t;

  // True when the instruction word fits a mask and pattern pair.
  function automatic logic op_match(input logic [13:0] word,
                                    input logic [13:0] mask,
                                    input logic [13:0] pat);
    op_match = ((word & mask) == pat);
  endfunction

endpackage

// File: rtl/pointer_calc.sv
// Effective address and next pointer value for the indirect store.
`timescale 1ns/1ps
module pointer_calc
(
  input  wire logic [15:0] ptr_val,
  input  wire logic [1:0]  update_code,
  input  wire logic        relative,
  input  wire logic [5:0]  offset,
  output logic      [15:0] eff_addr,
  output logic      [15:0] ptr_next
);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Plain 16-bit sums drop the carry, so both ends wrap modulo 65536.
  wire logic [15:0] ptr_inc;
  wire logic [15:0] ptr_dec;
  wire logic [15:0] off_ext;
  wire logic [15:0] ptr_rel;
  wire logic        is_pre_inc;
  wire logic        is_pre_dec;
  wire logic        is_inc;

  assign ptr_inc = ptr_val + move_exec_pkg::PTR_STEP;
  assign ptr_dec = ptr_val - move_exec_pkg::PTR_STEP;
  assign off_ext = {{10{offset[5]}}, offset};
  assign ptr_rel = ptr_val + off_ext;

  assign is_pre_inc = (update_code == move_exec_pkg::UPD_PRE_INC);
  assign is_pre_dec = (update_code == move_exec_pkg::UPD_PRE_DEC);
  assign is_inc     = is_pre_inc || (update_code == move_exec_pkg::UPD_POST_INC);

  assign eff_addr = relative   ? ptr_rel :
                    is_pre_inc ? ptr_inc :
                    is_pre_dec ? ptr_dec : ptr_val;

  assign ptr_next = relative ? ptr_val :
                    is_inc   ? ptr_inc : ptr_dec;

endmodule

// File: rtl/data_ram.sv
// Small data memory with one write port and a registered read port.
`timescale 1ns/1ps
module data_ram
#(
  parameter int AW = 8,
  parameter int DW = 8
)
(
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_r;

  // Contents carry no reset; software must write before it reads.
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data is registered, so a read answers one cycle later.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rd_data_r <= '0;
    end
    else if (rd_en)
    begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule

// File: rtl/literal_and_indirect_move_exec.sv
// Execution of the literal loads, direct store and indirect store of the core.
`timescale 1ns/1ps
module literal_and_indirect_move_exec
#(
  parameter int RAM_AW = 8
)
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic        ptr_load_en,
  input  wire logic        ptr_load_sel,
  input  wire logic [15:0] ptr_load_val,
  input  wire logic        status_wr_en,
  input  wire logic [2:0]  status_wr_data,
  input  wire logic [6:0]  ext_addr,
  input  wire logic        ext_wr_en,
  input  wire logic [7:0]  ext_wr_data,
  input  wire logic        ext_rd_en,
  output logic      [7:0]  accumulator,
  output logic      [6:0]  program_counter_high_latch,
  output logic      [15:0] pointer_register0,
  output logic      [15:0] pointer_register1,
  output logic      [2:0]  status_flags,
  output logic             mem_wr_en,
  output logic      [15:0] mem_wr_addr,
  output logic      [7:0]  mem_wr_data,
  output logic      [7:0]  ext_rd_data,
  output logic             ext_rd_valid,
  output logic             ext_wr_refused
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  logic [6:0]  page_r;
  logic [6:0]  page_nxt;
  logic [15:0] ptr0_r;
  logic [15:0] ptr0_nxt;
  logic [15:0] ptr1_r;
  logic [15:0] ptr1_nxt;
  logic [2:0]  status_r;
  logic        mem_wr_en_r;
  logic [15:0] mem_wr_addr_r;
  logic [7:0]  mem_wr_data_r;
  logic        ext_rd_valid_r;
  logic        ext_wr_refused_r;

  // ----------------------------------------------------------------
  // Window redirection
  // ----------------------------------------------------------------
  // Maps a 7-bit file address to a full data address; the window
  // locations are replaced by the pointer they stand for.
  function automatic logic [15:0] resolve(input logic [6:0]  faddr,
                                          input logic [15:0] p0,
                                          input logic [15:0] p1);
    if (faddr == move_exec_pkg::WIN0_ADDR)
    begin
      resolve = p0;
    end
    else if (faddr == move_exec_pkg::WIN1_ADDR)
    begin
      resolve = p1;
    end
    else
    begin
      resolve = {9'h000, faddr};
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic                 hit_page;
  wire logic                 hit_acc;
  wire logic                 hit_file;
  wire logic                 hit_ind;
  wire logic                 hit_rel;
  move_exec_pkg::op_kind_t   op_kind;

  assign hit_page = move_exec_pkg::op_match(instr, move_exec_pkg::PAGE_MASK,
                                            move_exec_pkg::PAGE_PAT);
  assign hit_acc  = move_exec_pkg::op_match(instr, move_exec_pkg::ACC_MASK,
                                            move_exec_pkg::ACC_PAT);
  assign hit_file = move_exec_pkg::op_match(instr, move_exec_pkg::FILE_MASK,
                                            move_exec_pkg::FILE_PAT);
  assign hit_ind  = move_exec_pkg::op_match(instr, move_exec_pkg::IND_MASK,
                                            move_exec_pkg::IND_PAT);
  assign hit_rel  = move_exec_pkg::op_match(instr, move_exec_pkg::REL_MASK,
                                            move_exec_pkg::REL_PAT);

  // The page load overlaps the accumulator load's don't-care bits, so it is tested first.
  assign op_kind = !instr_valid ? move_exec_pkg::OP_NONE :
                   hit_page     ? move_exec_pkg::OP_PAGE :
                   hit_acc      ? move_exec_pkg::OP_ACC  :
                   hit_file     ? move_exec_pkg::OP_FILE :
                   hit_ind      ? move_exec_pkg::OP_IND  :
                   hit_rel      ? move_exec_pkg::OP_REL  :
                                  move_exec_pkg::OP_NONE;

  // ----------------------------------------------------------------
  // Operand fields
  // ----------------------------------------------------------------
  wire logic [7:0] lit_byte;
  wire logic [6:0] lit_page;
  wire logic [6:0] file_addr;
  wire logic [1:0] upd_code;
  wire logic [5:0] rel_off;
  wire logic       is_rel;
  wire logic       ptr_sel;

  assign lit_byte  = instr[move_exec_pkg::LIT_LSB +: 8];
  assign lit_page  = instr[move_exec_pkg::LIT_LSB +: 7];
  assign file_addr = instr[move_exec_pkg::FILE_LSB +: 7];
  assign upd_code  = instr[move_exec_pkg::CODE_LSB +: 2];
  assign rel_off   = instr[move_exec_pkg::OFF_LSB +: 6];
  assign is_rel    = (op_kind == move_exec_pkg::OP_REL);

  assign ptr_sel = is_rel ? instr[move_exec_pkg::REL_SEL_BIT]
                          : instr[move_exec_pkg::IND_SEL_BIT];

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  wire logic [15:0] ptr_cur;
  wire logic [15:0] ind_addr;
  wire logic [15:0] ptr_upd;
  wire logic        ind_op;

  assign ptr_cur = ptr_sel ? ptr1_r : ptr0_r;
  assign ind_op  = (op_kind == move_exec_pkg::OP_IND) || is_rel;

  pointer_calc u_pointer_calc
  (
    .ptr_val     (ptr_cur),
    .update_code (upd_code),
    .relative    (is_rel),
    .offset      (rel_off),
    .eff_addr    (ind_addr),
    .ptr_next    (ptr_upd)
  );

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  // load high latch.
  assign page_nxt = (op_kind == move_exec_pkg::OP_PAGE) ? lit_page : page_r;
  assign acc_nxt  = (op_kind == move_exec_pkg::OP_ACC) ? lit_byte : acc_r;

  // The store's own pointer update wins over a load from the core for the
  // same pointer; a load of the other pointer still goes ahead.
  // pointer post-update.
  assign ptr0_nxt = (ind_op && !ptr_sel)           ? ptr_upd      :
                    (ptr_load_en && !ptr_load_sel) ? ptr_load_val : ptr0_r;
  assign ptr1_nxt = (ind_op && ptr_sel)            ? ptr_upd      :
                    (ptr_load_en && ptr_load_sel)  ? ptr_load_val : ptr1_r;

  // ----------------------------------------------------------------
  // Memory write selection
  // ----------------------------------------------------------------
  wire logic        file_op;
  wire logic        instr_wr;
  wire logic        ext_wr_go;
  wire logic        wr_go;
  wire logic [15:0] file_res_addr;
  wire logic [15:0] ext_res_addr;
  wire logic [15:0] wr_addr;
  wire logic [7:0]  wr_data;

  assign file_op = (op_kind == move_exec_pkg::OP_FILE);
  assign file_res_addr = resolve(file_addr, ptr0_r, ptr1_r);
  assign ext_res_addr  = resolve(ext_addr, ptr0_r, ptr1_r);

  // An instruction write owns the single port; a clashing outside write is
  // dropped and flagged rather than delayed, to keep the core single-cycle.
  assign instr_wr  = file_op || ind_op;
  assign ext_wr_go = ext_wr_en && !instr_wr;
  assign wr_go     = instr_wr || ext_wr_go;

  assign wr_addr = ind_op  ? ind_addr      :
                   file_op ? file_res_addr : ext_res_addr;
  assign wr_data = instr_wr ? acc_r : ext_wr_data;

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  // Only the low address bits reach the array; higher pointer bits alias.
  data_ram
  #(
    .AW (RAM_AW),
    .DW (move_exec_pkg::DATA_W)
  )
  u_data_ram
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (wr_go),
    .wr_addr (wr_addr[RAM_AW-1:0]),
    .wr_data (wr_data),
    .rd_en   (ext_rd_en),
    .rd_addr (ext_res_addr[RAM_AW-1:0]),
    .rd_data (ext_rd_data)
  );

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  // one-cycle update.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      acc_r  <= move_exec_pkg::ACC_RST;
      page_r <= move_exec_pkg::PAGE_RST;
      ptr0_r <= move_exec_pkg::PTR_RST;
      ptr1_r <= move_exec_pkg::PTR_RST;
    end
    else
    begin
      acc_r  <= acc_nxt;
      page_r <= page_nxt;
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
    end
  end

  // Status changes only on the ALU's own write; no move here touches it.
  // flags left alone.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      status_r <= move_exec_pkg::STAT_RST;
    end
    else if (status_wr_en)
    begin
      status_r <= status_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Observation registers
  // ----------------------------------------------------------------
  // Echo of the write just made, so the outside sees every store.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mem_wr_en_r      <= 1'b0;
      mem_wr_addr_r    <= 16'h0000;
      mem_wr_data_r    <= 8'h00;
      ext_rd_valid_r   <= 1'b0;
      ext_wr_refused_r <= 1'b0;
    end
    else
    begin
      mem_wr_en_r      <= wr_go;
      mem_wr_addr_r    <= wr_go ? wr_addr : mem_wr_addr_r;
      mem_wr_data_r    <= wr_go ? wr_data : mem_wr_data_r;
      ext_rd_valid_r   <= ext_rd_en;
      ext_wr_refused_r <= ext_wr_en && instr_wr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign accumulator                = acc_r;
  assign program_counter_high_latch = page_r;
  assign pointer_register0          = ptr0_r;
  assign pointer_register1          = ptr1_r;
  assign status_flags               = status_r;
  assign mem_wr_en                  = mem_wr_en_r;
  assign mem_wr_addr                = mem_wr_addr_r;
  assign mem_wr_data                = mem_wr_data_r;
  assign ext_rd_valid               = ext_rd_valid_r;
  assign ext_wr_refused             = ext_wr_refused_r;

endmodule

// File: verif/move_exec_chk.sv
// Concurrent checks on the ports of the data-move execution block.
`timescale 1ns/1ps
module move_exec_chk
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic        ptr_load_en,
  input wire logic        status_wr_en,
  input wire logic        ext_wr_en,
  input wire logic        ext_rd_en,
  input wire logic [7:0]  accumulator,
  input wire logic [6:0]  program_counter_high_latch,
  input wire logic [15:0] pointer_register0,
  input wire logic [15:0] pointer_register1,
  input wire logic [2:0]  status_flags,
  input wire logic        mem_wr_en,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [7:0]  mem_wr_data,
  input wire logic        ext_rd_valid
);
  // ----------------------------------------------------------------
  // Independent decode
  // ----------------------------------------------------------------
  // Decoded from raw bit fields so a wrong mask in the design shows up.
  wire logic        page = instr_valid && (instr[13:7] == 7'h63);
  // The page-latch load sits inside the accumulator load's don't-care space and wins there.
  wire logic        accl = instr_valid && (instr[13:10] == 4'hc) && !page;
  wire logic        file = instr_valid && (instr[13:7] == 7'h01);
  wire logic        ind  = instr_valid && (instr[13:3] == 11'h003);
  wire logic        rel  = instr_valid && (instr[13:7] == 7'h7f);
  wire logic        sel  = rel ? instr[6] : instr[2];
  wire logic [15:0] ptr  = sel ? pointer_register1 : pointer_register0;
  wire logic [15:0] oth  = sel ? pointer_register0 : pointer_register1;
  wire logic [15:0] pnx  = rel ? ptr : (instr[0] ? ptr - 16'h0001 : ptr + 16'h0001);
  wire logic [15:0] ea   = rel ? ptr + {{10{instr[5]}}, instr[5:0]} : (instr[1] ? ptr : pnx);
  wire logic [15:0] fa   = (instr[6:1] == 6'h00) ? (instr[0] ? pointer_register1 :
                           pointer_register0) : {9'h000, instr[6:0]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  page_load_a: assert property (
    page |=> program_counter_high_latch == $past(instr[6:0]))
    else $error("page latch not loaded with literal");
  acc_load_a: assert property (
    accl |=> accumulator == $past(instr[7:0]))
    else $error("accumulator not loaded with literal");
  file_store_a: assert property (
    file |=> mem_wr_en && mem_wr_addr == $past(fa) && mem_wr_data == $past(accumulator))
    else $error("direct store wrong address or data");
  ind_addr_a: assert property (
    (ind || rel) |=> mem_wr_en && mem_wr_addr == $past(ea) && mem_wr_data == $past(accumulator))
    else $error("indirect store wrong address or data");
  ptr_step_a: assert property (
    (ind || rel) |=> ($past(sel) ? pointer_register1 : pointer_register0) == $past(pnx))
    else $error("selected pointer not updated as expected");
  ptr_other_a: assert property (
    (ind || rel) && !ptr_load_en |=> ($past(sel) ? pointer_register0 : pointer_register1)
      == $past(oth))
    else $error("unselected pointer changed");
  flags_kept_a: assert property (
    !status_wr_en |=> $stable(status_flags))
    else $error("status flags changed by a move");
  read_served_a: assert property (
    ext_rd_en |=> ext_rd_valid)
    else $error("window read not answered next cycle");
  no_stray_a: assert property (
    !(file || ind || rel) && !ext_wr_en |=> !mem_wr_en)
    else $error("memory write without a cause");

  cover property (rel && instr[5]);
  cover property (ind && sel);
  cover property (file && instr[6:1] == 6'h00);
endmodule

// File: verif/testbench.sv
// Self-checking bench for the data-move execution block.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic        ptr_load_en = 1'b0;
  logic        ptr_load_sel = 1'b0;
  logic [15:0] ptr_load_val = 16'h0000;
  logic        status_wr_en = 1'b0;
  logic [2:0]  status_wr_data = 3'h0;
  logic [6:0]  ext_addr = 7'h00;
  logic        ext_wr_en = 1'b0;
  logic [7:0]  ext_wr_data = 8'h00;
  logic        ext_rd_en = 1'b0;
  logic [7:0]  accumulator;
  logic [6:0]  program_counter_high_latch;
  logic [15:0] pointer_register0;
  logic [15:0] pointer_register1;
  logic [2:0]  status_flags;
  logic        mem_wr_en;
  logic [15:0] mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic [7:0]  ext_rd_data;
  logic        ext_rd_valid;
  logic        ext_wr_refused;
  // Reference state of the block, advanced as stimulus is applied.
  logic [7:0]  acc_m = 8'h00;
  logic [6:0]  pcl_m = 7'h00;
  logic [15:0] p_m [2] = '{16'h0000, 16'h0000};
  logic [2:0]  st_m = 3'h0;
  logic        ref_m = 1'b0;
  logic [7:0]  mem_m [256];
  logic [23:0] wq [$];
  logic [7:0]  rq [$];
  logic [31:0] lfsr_r = 32'hcb13e0f7;
  logic [31:0] r;
  int          fail_count = 0;
  int          num_checks = 0;

  literal_and_indirect_move_exec #(.RAM_AW(8)) i_literal_and_indirect_move_exec
  (.clk_sys, .nrst, .instr_valid, .instr, .ptr_load_en, .ptr_load_sel, .ptr_load_val,
   .status_wr_en, .status_wr_data, .ext_addr, .ext_wr_en, .ext_wr_data, .ext_rd_en,
   .accumulator, .program_counter_high_latch, .pointer_register0, .pointer_register1,
   .status_flags, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .ext_rd_data, .ext_rd_valid,
   .ext_wr_refused);

  // 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h80200003)};
    return lfsr_r;
  endfunction

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One cycle of stimulus: checks state left by the previous cycle, then applies new inputs.
  task automatic cyc(input logic [13:0] w, input logic v = 1'b1, input logic xw = 1'b0,
                     input logic xr = 1'b0, input logic [6:0] xa = 7'h00,
                     input logic [7:0] xd = 8'h00, input logic le = 1'b0,
                     input logic ls = 1'b0, input logic [15:0] lv = 16'h0000);
    logic        st;
    logic        ind;
    logic        s;
    logic [15:0] a;
    logic [15:0] p;
    @(negedge clk_sys);
    check("accumulator", {16'h0000, acc_m}, {16'h0000, accumulator});
    check("page_latch", {17'h00000, pcl_m}, {17'h00000, program_counter_high_latch});
    check("pointer0", {8'h00, p_m[0]}, {8'h00, pointer_register0});
    check("pointer1", {8'h00, p_m[1]}, {8'h00, pointer_register1});
    check("status", {21'h000000, st_m}, {21'h000000, status_flags});
    check("refused", {23'h000000, ref_m}, {23'h000000, ext_wr_refused});
    instr_valid = v;
    instr = w;
    ext_wr_en = xw;
    ext_rd_en = xr;
    ext_addr = xa;
    ext_wr_data = xd;
    ptr_load_en = le;
    ptr_load_sel = ls;
    ptr_load_val = lv;
    status_wr_en = 1'b0;
    ind = v && (w[13:3] == 11'h003);
    st = ind || (v && (w[13:7] == 7'h01 || w[13:7] == 7'h7f));
    // Window addresses redirect through the pointer held before this edge.
    a = (xa[6:1] == 6'h00) ? p_m[xa[0]] : {9'h000, xa};
    if (xr) rq.push_back(mem_m[a[7:0]]);
    ref_m = xw && st;
    if (xw && !st) wq.push_back({a, xd});
    if (xw && !st) mem_m[a[7:0]] = xd;
    s = (w[13:7] == 7'h7f) ? w[6] : w[2];
    p = p_m[s];
    if (!v) a = 16'h0000;
    else if (w[13:7] == 7'h63) pcl_m = w[6:0];
    else if (w[13:10] == 4'hc) acc_m = w[7:0];
    else if (w[13:7] == 7'h01) a = (w[6:1] == 6'h00) ? p_m[w[0]] : {9'h000, w[6:0]};
    else if (ind) a = w[1] ? p : (w[0] ? p - 16'h0001 : p + 16'h0001);
    else if (w[13:7] == 7'h7f) a = p + {{10{w[5]}}, w[5:0]};
    if (ind) p_m[s] = w[0] ? p - 16'h0001 : p + 16'h0001;
    // A pointer load loses to any indirect store, offset form included, on the same pointer.
    if (le && !((ind || (v && w[13:7] == 7'h7f)) && ls == s)) p_m[ls] = lv;
    if (st) wq.push_back({a, acc_m});
    if (st) mem_m[a[7:0]] = acc_m;
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  // Each write or read answer consumes the oldest note left by the driver.
  always @(negedge clk_sys)
  begin
    if (mem_wr_en === 1'b1)
      check("mem_write", wq.size() ? wq.pop_front() : 24'hxxxxxx, {mem_wr_addr, mem_wr_data});
    if (ext_rd_valid === 1'b1)
      check("ext_read", {16'h0000, rq.size() ? rq.pop_front() : 8'hxx}, {16'h0000, ext_rd_data});
  end

  // Watchdog so a stuck run still reaches the verdict.
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    status_wr_en = 1'b1;
    status_wr_data = 3'h5;
    st_m = 3'h5;
    cyc(14'h31ff);
    cyc(14'h3180);
    cyc(14'h33ff);
    cyc(14'h3000);
    cyc(14'h0000, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, 16'hffff);
    cyc(14'h0000, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 1'b1, 16'h0000);
    // Every update code on both pointers, starting at the wrap boundaries.
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      cyc({6'h30, r[7:0]});
      cyc({11'h003, i[2:0]});
    end
    cyc({7'h7f, 7'h20});
    cyc({7'h7f, 7'h5f});
    cyc({7'h7f, 7'h1f}, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, 16'h8000);
    cyc(14'h0018, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, 16'h1234);
    cyc(14'h30c3);
    cyc(14'h0080);
    cyc(14'h0081);
    cyc(14'h00ff);
    cyc(14'h0082, 1'b1, 1'b1, 1'b0, 7'h05, 8'h3c);
    cyc(14'h0000, 1'b0, 1'b1, 1'b0, 7'h01, 8'ha5);
    cyc(14'h0000, 1'b0);
    cyc(14'h0000, 1'b0, 1'b0, 1'b1, 7'h00);
    cyc(14'h0000, 1'b0, 1'b0, 1'b1, 7'h01);
    cyc(14'h0000, 1'b0, 1'b0, 1'b1, 7'h7f);
    // Random back-to-back mix of all moves and pointer loads.
    for (int i = 0; i < 60; i++)
    begin
      r = rnd();
      case (r[2:0])
        3'h0: cyc({7'h63, r[13:7]});
        3'h1: cyc({4'hc, r[9:8], r[21:14]});
        3'h2: cyc({7'h01, r[14:8]});
        3'h3: cyc({11'h003, r[10:8]});
        3'h4: cyc({7'h7f, r[14:8]});
        3'h5: cyc(14'h0000);
        default: cyc(14'h0000, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1, r[3], r[31:16]);
      endcase
    end
    cyc(14'h0000, 1'b0);
    cyc(14'h0000, 1'b0);
    check("queues", 24'h000000, 24'(wq.size() + rq.size()));
    results();
  end
endmodule

bind literal_and_indirect_move_exec move_exec_chk i_move_exec_chk
(.clk_sys, .nrst, .instr_valid, .instr, .ptr_load_en, .status_wr_en, .ext_wr_en, .ext_rd_en,
 .accumulator, .program_counter_high_latch, .pointer_register0, .pointer_register1,
 .status_flags, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .ext_rd_valid);
